// >>> rtl/dispkey_pkg.sv
// constants and types shared by the display, fan and key command handler
package dispkey_pkg;

   // request packet types
   localparam logic [7:0] TYP_CURSOR_POS = 8'h0b;
   localparam logic [7:0] TYP_CURSOR_STYLE = 8'h0c;
   localparam logic [7:0] TYP_CONTRAST = 8'h0d;
   localparam logic [7:0] TYP_BACKLIGHT = 8'h0e;
   localparam logic [7:0] TYP_FAN_REPORT = 8'h10;
   localparam logic [7:0] TYP_FAN_POWER = 8'h11;
   localparam logic [7:0] TYP_SENSOR_INFO = 8'h12;
   localparam logic [7:0] TYP_TEMP_REPORT = 8'h13;
   localparam logic [7:0] TYP_BUS_XACT = 8'h14;
   localparam logic [7:0] TYP_LCD_DIRECT = 8'h16;
   localparam logic [7:0] TYP_KEY_MASKS = 8'h17;
   localparam logic [7:0] TYP_KEY_POLL = 8'h18;
   localparam logic [7:0] ACK_FLAG = 8'h40;
   localparam logic [7:0] ERR_FLAG = 8'hc0;
   localparam logic [7:0] TYP_FAN_SPEED_RPT = 8'h81;

   // parameter limits
   localparam logic [7:0] COL_MAX = 8'h13;
   localparam logic [7:0] ROW_MAX = 8'h03;
   localparam logic [7:0] STYLE_MAX = 8'h03;
   localparam logic [7:0] CONTRAST_MAX = 8'hfe;
   localparam logic [7:0] LEVEL_MAX = 8'h64;
   localparam logic [7:0] FAN_MASK_MAX = 8'h0f;
   localparam logic [7:0] SENSOR_IDX_MAX = 8'h0f;
   localparam logic [7:0] BUS_IDX_NONE = 8'h20;
   localparam logic [7:0] BUS_READ_MAX = 8'h0e;
   localparam logic [7:0] LCD_LOC_MAX = 8'h02;
   localparam logic [7:0] KEY_MASK_MAX = 8'h3f;
   localparam logic [4:0] LEN_XACT_MIN = 5'h02;
   localparam logic [4:0] LEN_XACT_MAX = 5'h10;
   localparam logic [6:0] LEVEL_FULL = 7'h64;

   // single-wire sensor bus
   localparam logic [7:0] MATCH_ROM = 8'h55;
   localparam logic [7:0] CRC_POLY = 8'h8c;
   localparam logic [3:0] ROM_BYTES = 4'h8;

   // time base: reports and fan forcing run on eighth-second slots
   localparam int CLK_PERIOD_NS = 10;
   localparam int EIGHTH_SEC_NS = 125000000;
   localparam int EIGHTH_SEC_CYCLES = EIGHTH_SEC_NS / CLK_PERIOD_NS;

   // power-up settings
   localparam logic [7:0] CONTRAST_RST = 8'h78;
   localparam logic [6:0] BACKLIGHT_RST = 7'h64;
   localparam logic [6:0] FAN_POWER_RST = 7'h64;
   localparam logic [5:0] KEY_MASK_RST = 6'h3f;

   typedef enum logic [1:0] {BUS_RESET, BUS_WRITE, BUS_READ} bus_op_t;
   typedef enum logic [2:0] {OW_IDLE, OW_RESET, OW_ADDR, OW_WRITE, OW_READ} ow_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] typ;
      logic [4:0] len;
      logic [15:0][7:0] data;
   } pkt_t;

   typedef struct packed {
      logic [4:0] col;
      logic [1:0] row;
      logic [2:0] style;
      logic [7:0] contrast;
      logic [6:0] bl_disp;
      logic [6:0] bl_key;
      logic [3:0][6:0] fan_power;
      logic [3:0] fan_mask;
      logic [15:0] temp_mask;
      logic [5:0] press_mask;
      logic [5:0] release_mask;
   } settings_t;

   typedef struct packed {
      logic valid;
      bus_op_t op;
      logic [7:0] wdata;
   } bus_cmd_t;

   typedef struct packed {
      logic wr;
      logic [1:0] sel;
      logic [7:0] data;
   } lcd_cmd_t;

   typedef struct packed {
      logic [5:0] press;
      logic [5:0] release_;
   } key_evt_t;

endpackage

// >>> rtl/display_fan_key_command_handler.sv
// request decoder and settings store for the display, fan and key command set
// Summary of operation
// - ack type is request type plus 0x40
// - cursor position: column, row, ack 0x4b
// - cursor style 0..3 applied, ack 0x4c
// - contrast 0..254 applied, ack 0x4d
// - one backlight byte sets both levels
// - two bytes: display then keypad, ack 0x4e
// - fan report mask 0..15, ack 0x50
// - enabled fans reported each 500 ms, staggered
// - reported fan forced full one eighth-second
// - four fan power levels, ack 0x51
// - sensor info: index plus eight ROM bytes
// - bus transaction: index, read count, payload
// - bus reset, address, write, read order
// - index 32 or index not enumerated: no address; else match ROM
// - write length minus two payload bytes
// - read count bytes, reply index data crc
// - direct controller write, location selects register
// - key masks press and release, ack 0x57
// - all key events reported after power-up
// - poll returns state, presses, releases; clears
// - poll ignores the reporting masks
// - settings bundle kept for boot-state store
`timescale 1ns/1ps
`default_nettype none

module display_fan_key_command_handler
   import dispkey_pkg::*;
#(
   parameter int EIGHTH_CYCLES = EIGHTH_SEC_CYCLES
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire pkt_t req, // request packet, valid one cycle
   output logic req_ready, // request may be taken
   output pkt_t reply, // answer packet, valid one cycle
   input wire logic [5:0] key_in, // current key levels
   output key_evt_t key_evt, // masked key edges, one cycle
   input wire logic [31:0][7:0][7:0] rom_table, // enumerated ROM ids
   input wire logic [31:0] rom_present, // device found per index
   output bus_cmd_t bus_cmd, // sensor bus operation, one cycle
   input wire logic bus_done, // bus operation finished
   input wire logic [7:0] bus_rdata, // byte read with bus_done
   output lcd_cmd_t lcd_cmd, // direct controller write
   output settings_t settings, // stored settings
   output logic [3:0][6:0] fan_drive, // effective fan power
   output logic [3:0] fan_report, // fan speed report due, one cycle
   output logic temp_report // temperature report due, one cycle
);

   typedef struct packed {
      logic req_ready;
      pkt_t reply;
      settings_t cfg;
      logic [3:0][6:0] fan_drive;
      logic [3:0] fan_report;
      logic temp_report;
      logic [5:0] key_prev;
      logic [5:0] pressed_since;
      logic [5:0] released_since;
      key_evt_t key_evt;
      lcd_cmd_t lcd;
      logic [31:0] tick;
      logic [2:0] slot;
      ow_state_t ow_st;
      logic ow_wait;
      logic [3:0] ow_cnt;
      logic [5:0] ow_idx;
      logic ow_addr;
      logic [3:0] ow_nread;
      logic [3:0] ow_nwrite;
      logic [13:0][7:0] ow_wbuf;
      logic [7:0] ow_crc;
      bus_cmd_t bus;
   } state_t;

   state_t s_r;
   state_t s_nxt;
   logic [5:0] press_now;
   logic [5:0] rel_now;
   logic take;
   logic ok;
   logic ow_start;
   logic ow_fin;
   logic [7:0] d0;
   logic [7:0] d1;
   logic [7:0] crc_nxt;

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] x;
      x = c;
      for (int i = 0; i < 8; i++) begin
         x = (x[0] ^ d[i]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.reply.valid = 1'b0;
      s_nxt.fan_report = '0;
      s_nxt.temp_report = 1'b0;
      s_nxt.lcd.wr = 1'b0;
      s_nxt.bus.valid = 1'b0;
      take = req.valid && s_r.req_ready;
      ok = 1'b0;
      ow_start = 1'b0;
      ow_fin = 1'b0;
      d0 = req.data[0];
      d1 = req.data[1];
      crc_nxt = crc_step(s_r.ow_crc, bus_rdata);

      // eighth-second slots: fan k owns slot k of each half second
      if (s_r.tick == 32'(EIGHTH_CYCLES - 1)) begin
         s_nxt.tick = '0;
         s_nxt.slot = s_r.slot + 3'h1;
         for (int k = 0; k < 4; k++) begin
            if (s_r.cfg.fan_mask[k] && s_nxt.slot[1:0] == 2'(k)) begin
               s_nxt.fan_report[k] = 1'b1;
            end
         end
         if (s_nxt.slot == 3'h0 && s_r.cfg.temp_mask != 16'h0000) begin
            s_nxt.temp_report = 1'b1;
         end
      end else begin
         s_nxt.tick = s_r.tick + 32'h1;
      end

      // key edges; masks gate only the event outputs, not the poll sets
      press_now = key_in & ~s_r.key_prev;
      rel_now = ~key_in & s_r.key_prev;
      s_nxt.key_prev = key_in;
      s_nxt.key_evt.press = press_now & s_r.cfg.press_mask;
      s_nxt.key_evt.release_ = rel_now & s_r.cfg.release_mask;
      s_nxt.pressed_since = s_r.pressed_since | press_now;
      s_nxt.released_since = s_r.released_since | rel_now;

      if (take) begin
         s_nxt.reply.len = '0;
         s_nxt.reply.data = '0;
         case (req.typ)
            TYP_CURSOR_POS: begin
               ok = req.len == 5'h02 && d0 <= COL_MAX && d1 <= ROW_MAX;
               if (ok) begin
                  s_nxt.cfg.col = d0[4:0];
                  s_nxt.cfg.row = d1[1:0];
               end
            end
            TYP_CURSOR_STYLE: begin
               ok = req.len == 5'h01 && d0 <= STYLE_MAX;
               if (ok) s_nxt.cfg.style = d0[2:0];
            end
            TYP_CONTRAST: begin
               ok = req.len == 5'h01 && d0 <= CONTRAST_MAX;
               if (ok) s_nxt.cfg.contrast = d0;
            end
            TYP_BACKLIGHT: begin
               if (req.len == 5'h01 && d0 <= LEVEL_MAX) begin
                  ok = 1'b1;
                  s_nxt.cfg.bl_disp = d0[6:0];
                  s_nxt.cfg.bl_key = d0[6:0];
               end else if (req.len == 5'h02 && d0 <= LEVEL_MAX && d1 <= LEVEL_MAX) begin
                  ok = 1'b1;
                  s_nxt.cfg.bl_disp = d0[6:0];
                  s_nxt.cfg.bl_key = d1[6:0];
               end
            end
            TYP_FAN_REPORT: begin
               ok = req.len == 5'h01 && d0 <= FAN_MASK_MAX;
               if (ok) s_nxt.cfg.fan_mask = d0[3:0];
            end
            TYP_FAN_POWER: begin
               ok = req.len == 5'h04;
               for (int k = 0; k < 4; k++) begin
                  if (req.data[k] > LEVEL_MAX) ok = 1'b0;
               end
               if (ok) begin
                  for (int k = 0; k < 4; k++) begin
                     s_nxt.cfg.fan_power[k] = req.data[k][6:0];
                  end
               end
            end
            TYP_SENSOR_INFO: begin
               ok = req.len == 5'h01 && d0 <= SENSOR_IDX_MAX;
               if (ok) begin
                  s_nxt.reply.len = 5'h09;
                  s_nxt.reply.data[0] = d0;
                  for (int j = 0; j < 8; j++) begin
                     s_nxt.reply.data[j + 1] = rom_table[d0[4:0]][j];
                  end
               end
            end
            TYP_TEMP_REPORT: begin
               ok = req.len == 5'h04 && req.data[2] == 8'h00 && req.data[3] == 8'h00;
               if (ok) s_nxt.cfg.temp_mask = {d1, d0};
            end
            TYP_BUS_XACT: begin
               ok = req.len >= LEN_XACT_MIN && req.len <= LEN_XACT_MAX
                  && d0 <= BUS_IDX_NONE && d1 <= BUS_READ_MAX
                  && (req.len != LEN_XACT_MIN || d1 != 8'h00);
               if (ok) begin
                  ow_start = 1'b1;
                  s_nxt.req_ready = 1'b0;
                  s_nxt.ow_st = OW_RESET;
                  s_nxt.ow_wait = 1'b0;
                  s_nxt.ow_cnt = '0;
                  s_nxt.ow_idx = d0[5:0];
                  s_nxt.ow_nread = d1[3:0];
                  s_nxt.ow_nwrite = 4'(req.len - LEN_XACT_MIN);
                  s_nxt.ow_wbuf = req.data[15:2];
                  // index 32, or an index with nothing enumerated, skips the address phase
                  s_nxt.ow_addr = d0 < BUS_IDX_NONE && rom_present[d0[4:0]];
                  s_nxt.ow_crc = '0;
               end
            end
            TYP_LCD_DIRECT: begin
               ok = req.len == 5'h02 && d0 <= LCD_LOC_MAX;
               if (ok) begin
                  s_nxt.lcd.wr = 1'b1;
                  s_nxt.lcd.sel = d0[1:0];
                  s_nxt.lcd.data = d1;
               end
            end
            TYP_KEY_MASKS: begin
               ok = req.len == 5'h02 && d0 <= KEY_MASK_MAX && d1 <= KEY_MASK_MAX;
               if (ok) begin
                  s_nxt.cfg.press_mask = d0[5:0];
                  s_nxt.cfg.release_mask = d1[5:0];
               end
            end
            TYP_KEY_POLL: begin
               ok = req.len == 5'h00;
               if (ok) begin
                  // this cycle's edges go into the reply, so clearing loses none
                  s_nxt.reply.len = 5'h03;
                  s_nxt.reply.data[0] = {2'b00, key_in};
                  s_nxt.reply.data[1] = {2'b00, s_r.pressed_since | press_now};
                  s_nxt.reply.data[2] = {2'b00, s_r.released_since | rel_now};
                  s_nxt.pressed_since = '0;
                  s_nxt.released_since = '0;
               end
            end
            default: ok = 1'b0;
         endcase
         s_nxt.reply.valid = !ow_start;
         s_nxt.reply.typ = ok ? (req.typ | ACK_FLAG) : (req.typ | ERR_FLAG);
      end

      // sensor bus sequencer: each step issues one operation and waits for done
      unique case (s_r.ow_st)
         OW_IDLE: ;
         OW_RESET: begin
            if (!s_r.ow_wait) begin
               s_nxt.bus = '{valid: 1'b1, op: BUS_RESET, wdata: 8'h00};
               s_nxt.ow_wait = 1'b1;
            end else if (bus_done) begin
               s_nxt.ow_wait = 1'b0;
               s_nxt.ow_cnt = '0;
               s_nxt.ow_st = s_r.ow_addr ? OW_ADDR
                  : (s_r.ow_nwrite != 4'h0 ? OW_WRITE : OW_READ);
            end
         end
         OW_ADDR: begin
            if (!s_r.ow_wait) begin
               s_nxt.bus.valid = 1'b1;
               s_nxt.bus.op = BUS_WRITE;
               s_nxt.bus.wdata = (s_r.ow_cnt == 4'h0) ? MATCH_ROM
                  : rom_table[s_r.ow_idx[4:0]][s_r.ow_cnt - 4'h1];
               s_nxt.ow_wait = 1'b1;
            end else if (bus_done) begin
               s_nxt.ow_wait = 1'b0;
               if (s_r.ow_cnt == ROM_BYTES) begin
                  s_nxt.ow_cnt = '0;
                  s_nxt.ow_st = s_r.ow_nwrite != 4'h0 ? OW_WRITE : OW_READ;
               end else begin
                  s_nxt.ow_cnt = s_r.ow_cnt + 4'h1;
               end
            end
         end
         OW_WRITE: begin
            if (!s_r.ow_wait) begin
               s_nxt.bus.valid = 1'b1;
               s_nxt.bus.op = BUS_WRITE;
               s_nxt.bus.wdata = s_r.ow_wbuf[s_r.ow_cnt];
               s_nxt.ow_wait = 1'b1;
            end else if (bus_done) begin
               s_nxt.ow_wait = 1'b0;
               if (s_r.ow_cnt == s_r.ow_nwrite - 4'h1) begin
                  s_nxt.ow_cnt = '0;
                  if (s_r.ow_nread != 4'h0) s_nxt.ow_st = OW_READ;
                  else ow_fin = 1'b1;
               end else begin
                  s_nxt.ow_cnt = s_r.ow_cnt + 4'h1;
               end
            end
         end
         OW_READ: begin
            if (!s_r.ow_wait) begin
               s_nxt.bus.valid = 1'b1;
               s_nxt.bus.op = BUS_READ;
               s_nxt.bus.wdata = 8'h00;
               s_nxt.ow_wait = 1'b1;
            end else if (bus_done) begin
               s_nxt.ow_wait = 1'b0;
               s_nxt.reply.data[s_r.ow_cnt + 4'h1] = bus_rdata;
               s_nxt.ow_crc = crc_nxt;
               if (s_r.ow_cnt == s_r.ow_nread - 4'h1) ow_fin = 1'b1;
               else s_nxt.ow_cnt = s_r.ow_cnt + 4'h1;
            end
         end
      endcase

      if (ow_fin) begin
         s_nxt.ow_st = OW_IDLE;
         s_nxt.req_ready = 1'b1;
         s_nxt.reply.valid = 1'b1;
         s_nxt.reply.typ = TYP_BUS_XACT | ACK_FLAG;
         s_nxt.reply.len = 5'(s_r.ow_nread) + LEN_XACT_MIN;
         s_nxt.reply.data[0] = {2'b00, s_r.ow_idx};
         s_nxt.reply.data[s_r.ow_nread + 4'h1] = s_nxt.ow_crc;
      end

      for (int k = 0; k < 4; k++) begin
         s_nxt.fan_drive[k] = (s_nxt.cfg.fan_mask[k] && s_nxt.slot[1:0] == 2'(k))
            ? LEVEL_FULL : s_nxt.cfg.fan_power[k];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_r <= '0;
         s_r.req_ready <= 1'b1;
         s_r.cfg.contrast <= CONTRAST_RST;
         s_r.cfg.bl_disp <= BACKLIGHT_RST;
         s_r.cfg.bl_key <= BACKLIGHT_RST;
         s_r.cfg.fan_power <= {4{FAN_POWER_RST}};
         s_r.fan_drive <= {4{FAN_POWER_RST}};
         s_r.cfg.press_mask <= KEY_MASK_RST;
         s_r.cfg.release_mask <= KEY_MASK_RST;
         s_r.ow_st <= OW_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign req_ready = s_r.req_ready;
   assign reply = s_r.reply;
   assign key_evt = s_r.key_evt;
   assign bus_cmd = s_r.bus;
   assign lcd_cmd = s_r.lcd;
   assign settings = s_r.cfg;
   assign fan_drive = s_r.fan_drive;
   assign fan_report = s_r.fan_report;
   assign temp_report = s_r.temp_report;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ack_flag_a: assert property (take && req.typ != TYP_BUS_XACT |=> reply.valid
      && reply.typ[5:0] == $past(req.typ[5:0]) && reply.typ[7:6] != 2'b00)
      else $error("reply type not derived from request");
   cursor_pos_a: assert property (take && req.typ == TYP_CURSOR_POS && req.len == 5'h02
      && req.data[0] <= COL_MAX && req.data[1] <= ROW_MAX
      |=> settings.col == $past(req.data[0][4:0]) && reply.typ == 8'h4b)
      else $error("cursor position not applied");
   contrast_keep_a: assert property (take && req.typ == TYP_CONTRAST && req.data[0] == 8'hff
      |=> $stable(settings.contrast) && reply.typ == (TYP_CONTRAST | ERR_FLAG))
      else $error("out of range contrast accepted");
   bl_single_a: assert property (take && req.typ == TYP_BACKLIGHT && req.len == 5'h01
      && req.data[0] <= LEVEL_MAX
      |=> settings.bl_disp == settings.bl_key && settings.bl_key == $past(req.data[0][6:0]))
      else $error("single backlight byte not applied to both");
   bl_pair_a: assert property (take && req.typ == TYP_BACKLIGHT && req.len == 5'h02
      && req.data[0] <= LEVEL_MAX && req.data[1] <= LEVEL_MAX
      |=> settings.bl_key == $past(req.data[1][6:0]) && reply.typ == 8'h4e)
      else $error("keypad backlight not taken from second byte");
   fan_force_a: assert property (settings.fan_mask[0] && s_r.slot[1:0] == 2'h0
      |-> fan_drive[0] == LEVEL_FULL)
      else $error("reported fan not forced to full power");
   fan_free_a: assert property (s_r.slot[1:0] != 2'h0
      |-> fan_drive[0] == settings.fan_power[0])
      else $error("fan forced outside its slot");
   // the report pulse was decided with the mask of the cycle before
   fan_rpt_a: assert property (fan_report[0] |-> $past(settings.fan_mask[0])
      && s_r.slot[1:0] == 2'h0 && s_r.tick == 32'h0)
      else $error("fan report outside its slot");
   poll_a: assert property (take && req.typ == TYP_KEY_POLL && req.len == 5'h00
      |=> reply.len == 5'h03 && reply.data[0][5:0] == $past(key_in)
      ##1 s_r.pressed_since == $past(press_now))
      else $error("poll reply or clear wrong");
   bus_first_a: assert property (ow_start
      |=> !req_ready ##1 bus_cmd.valid && bus_cmd.op == BUS_RESET)
      else $error("bus transaction did not start with reset");
   bus_match_a: assert property (s_r.ow_st == OW_RESET && s_r.ow_wait && bus_done
      && s_r.ow_addr |=> ##1 bus_cmd.valid && bus_cmd.wdata == MATCH_ROM)
      else $error("match ROM not sent");

   ow_reply_c: cover property (reply.valid && reply.typ == (TYP_BUS_XACT | ACK_FLAG));
   fan_rpt_c: cover property (fan_report != 4'h0);
   poll_c: cover property (reply.valid && reply.typ == (TYP_KEY_POLL | ACK_FLAG));
   err_c: cover property (reply.valid && reply.typ[7:6] == 2'b11);

endmodule // display_fan_key_command_handler

`default_nettype wire

// >>> verif/sw_bus_model.sv
// behavioural single-wire sensor bus answering each operation after a delay
`timescale 1ns/1ps
`default_nettype none
module sw_bus_model import dispkey_pkg::*; (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire bus_cmd_t bus_cmd, // operation request
   input wire logic [3:0] delay, // cycles before done
   output logic bus_done, // operation finished
   output logic [7:0] bus_rdata // byte read
);
   logic [9:0] log_q[$];
   logic [3:0] cnt_r = 4'h0;
   logic busy_r = 1'b0;
   logic rd_r = 1'b0;
   initial bus_done = 1'b0;
   initial bus_rdata = 8'h00;
   // the line is not held outside a read, so stale data toggles every cycle
   always @(posedge clk_sys) begin
      bus_done <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (rst) begin
         busy_r <= 1'b0;
      end else if (bus_cmd.valid) begin
         busy_r <= 1'b1;
         cnt_r <= delay;
         rd_r <= (bus_cmd.op == BUS_READ);
         log_q.push_back({bus_cmd.op, bus_cmd.wdata});
      end else if (busy_r && cnt_r == 4'h0) begin
         busy_r <= 1'b0;
         bus_done <= 1'b1;
         if (rd_r) bus_rdata <= 8'h5a;
      end else if (busy_r) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
endmodule // sw_bus_model
`default_nettype wire

// >>> verif/tb_top.sv
// testbench for the display, fan and key command handler
`timescale 1ns/1ps
`default_nettype none
module tb_top import dispkey_pkg::*;;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   pkt_t req = '0;
   logic req_ready;
   pkt_t reply;
   logic [5:0] key_in = 6'h00;
   key_evt_t key_evt;
   logic [31:0][7:0][7:0] rom_table;
   logic [31:0] rom_present = 32'h0000_0008;
   bus_cmd_t bus_cmd;
   logic bus_done;
   logic [7:0] bus_rdata;
   lcd_cmd_t lcd_cmd;
   settings_t settings;
   logic [3:0][6:0] fan_drive;
   logic [3:0] fan_report;
   logic temp_report;
   logic [3:0] dly = 4'h0;
   int bad_count = 0;
   int total_checks = 0;
   int n_rpt = 0;
   int n_full = 0;
   int n_temp = 0;
   int mark_a = 0;
   int mark_b = 0;
   localparam logic [7:0] THERMO_FAMILY = 8'h3c; // arbitrary code of a supported thermometer
   key_evt_t evt_acc = '0;
   lcd_cmd_t lcd_seen = '0;
   always #5 clk_sys = ~clk_sys;
   display_fan_key_command_handler #(.EIGHTH_CYCLES(16)) DUT (.clk_sys(clk_sys), .rst(rst),
      .req(req), .req_ready(req_ready), .reply(reply), .key_in(key_in), .key_evt(key_evt),
      .rom_table(rom_table), .rom_present(rom_present), .bus_cmd(bus_cmd),
      .bus_done(bus_done), .bus_rdata(bus_rdata), .lcd_cmd(lcd_cmd), .settings(settings),
      .fan_drive(fan_drive), .fan_report(fan_report), .temp_report(temp_report));
   sw_bus_model mdl (.clk_sys(clk_sys), .rst(rst), .bus_cmd(bus_cmd), .delay(dly),
      .bus_done(bus_done), .bus_rdata(bus_rdata));
   always @(posedge clk_sys) begin
      evt_acc <= evt_acc | key_evt;
      if (lcd_cmd.wr) lcd_seen <= lcd_cmd;
      n_rpt <= n_rpt + int'(fan_report);
      n_full <= n_full + int'(fan_drive[0] === 7'h64);
      n_temp <= n_temp + int'(temp_report);
   end
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // one request, then wait (bounded) for the answer and check its type
   task automatic xfer(input logic [7:0] t, input logic [4:0] n, input logic [127:0] d,
         input logic [7:0] et);
      int w;
      w = 0;
      @(posedge clk_sys) req <= {1'b1, t, n, d};
      @(posedge clk_sys) req.valid <= 1'b0;
      #1;
      while (reply.valid !== 1'b1 && w < 300) begin
         @(posedge clk_sys) #1;
         w++;
      end
      chk({reply.valid, reply.typ}, {1'b1, et});
   endtask
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      for (int i = 0; i < 8; i++)
         c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8c : 8'h00);
      return c;
   endfunction
   initial begin
      repeat (5000) @(posedge clk_sys);
      bad_count++;
      stop_test();
   end
   initial begin
      for (int i = 0; i < 32; i++)
         for (int b = 0; b < 8; b++)
            rom_table[i][b] = 8'(i * 8 + b);
      rom_table[3][0] = THERMO_FAMILY;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys) #1;
      chk({settings.contrast, settings.press_mask, settings.release_mask}, 20'h78fff);
      xfer(TYP_CURSOR_POS, 5'h02, 128'h0313, 8'h4b);
      chk({settings.col, settings.row}, {5'h13, 2'h3});
      xfer(TYP_CURSOR_POS, 5'h02, 128'h0014, 8'hcb);
      chk(settings.col, 5'h13);
      for (int s = 0; s < 5; s++) begin
         xfer(TYP_CURSOR_STYLE, 5'h01, 128'(s), s < 4 ? 8'h4c : 8'hcc);
         chk(settings.style, s < 4 ? 3'(s) : 3'h3);
      end
      xfer(TYP_CONTRAST, 5'h01, 128'hfe, 8'h4d);
      xfer(TYP_CONTRAST, 5'h01, 128'hff, 8'hcd);
      chk(settings.contrast, 8'hfe);
      xfer(TYP_BACKLIGHT, 5'h01, 128'h32, 8'h4e);
      chk({settings.bl_disp, settings.bl_key}, {7'h32, 7'h32});
      xfer(TYP_BACKLIGHT, 5'h02, 128'h140a, 8'h4e);
      chk({settings.bl_disp, settings.bl_key}, {7'h0a, 7'h14});
      xfer(TYP_FAN_POWER, 5'h04, 128'h1e28321e, 8'h51);
      chk(settings.fan_power, {7'h1e, 7'h28, 7'h32, 7'h1e});
      xfer(TYP_FAN_REPORT, 5'h01, 128'h1, 8'h50);
      repeat (64) @(posedge clk_sys) #1;
      mark_a = n_rpt;
      mark_b = n_full;
      repeat (64) @(posedge clk_sys) #1;
      chk(n_rpt - mark_a, 1);
      chk(n_full - mark_b, 16);
      xfer(TYP_TEMP_REPORT, 5'h04, 128'h01000008, 8'hd3);
      xfer(TYP_TEMP_REPORT, 5'h04, 128'h0008, 8'h53);
      chk(settings.temp_mask, 16'h0008);
      mark_a = n_temp;
      repeat (128) @(posedge clk_sys) #1;
      chk(n_temp - mark_a, 1);
      xfer(TYP_SENSOR_INFO, 5'h01, 128'h03, 8'h52);
      chk({reply.len, reply.data[8:0]}, {5'h09, 56'h1f1e1d1c1b1a19, THERMO_FAMILY, 8'h03});
      for (int l = 0; l < 3; l++) begin
         xfer(TYP_LCD_DIRECT, 5'h02, {112'h0, 8'(8'h41 + l), 8'(l)}, 8'h56);
         repeat (2) @(posedge clk_sys) #1;
         chk(lcd_seen, {1'b1, 2'(l), 8'(8'h41 + l)});
      end
      xfer(TYP_KEY_MASKS, 5'h02, 128'h0040, 8'hd7);
      xfer(TYP_KEY_MASKS, 5'h02, 128'h0001, 8'h57);
      xfer(TYP_KEY_POLL, 5'h00, 128'h0, 8'h58);
      @(posedge clk_sys) key_in <= 6'h03;
      @(posedge clk_sys) key_in <= 6'h02;
      repeat (3) @(posedge clk_sys) #1;
      chk(evt_acc, {6'h01, 6'h00});
      xfer(TYP_KEY_POLL, 5'h00, 128'h0, 8'h58);
      chk({reply.len, reply.data[2:0]}, {5'h03, 24'h010302});
      xfer(TYP_KEY_POLL, 5'h00, 128'h0, 8'h58);
      chk(reply.data[2:0], 24'h000002);
      xfer(TYP_BUS_XACT, 5'h03, 128'h440103, 8'h54);
      chk({reply.len, reply.data[2:0]}, {5'h03, crc8(8'h00, 8'h5a), 16'h5a03});
      chk({10'(mdl.log_q.size()), mdl.log_q[0][9:8], mdl.log_q[1][7:0], mdl.log_q[2][7:0],
         mdl.log_q[10], mdl.log_q[11][9:8]},
         {10'd12, 2'h0, 8'h55, THERMO_FAMILY, 10'h144, 2'h2});
      mdl.log_q.delete();
      dly <= 4'h5;
      xfer(TYP_BUS_XACT, 5'h02, 128'h0220, 8'h54);
      chk({10'(mdl.log_q.size()), mdl.log_q[0][9:8], mdl.log_q[1][9:8], mdl.log_q[2][9:8]},
         {10'd3, 6'h0a});
      chk({reply.len, reply.data[3:0]}, {5'h04, crc8(crc8(8'h00, 8'h5a), 8'h5a), 24'h5a5a20});
      xfer(TYP_BUS_XACT, 5'h02, 128'h0020, 8'hd4);
      xfer(TYP_BUS_XACT, 5'h02, 128'h0121, 8'hd4);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
